// ==== src/eeprom_write_guard_bus_entry.sv ====
// Two-wire EEPROM front end with glitch filter and write guard
//
// Summary of operation
// R01: Pulses of 100 ns or less on clock or data are ignored.
// R02: While the write guard input is high, no array write happens.
// R03: Controller keeps the guard high from start through stop.
// R04: No write cycle begins while the supply monitor reports low supply.
// R05: Power-on reset holds the write logic idle during power-up.
// R06: Both address-select bits are held internally, default zero.
// R07: Controller sends the select code right after the device code.
// R08: Controller keeps data high, clock defined, no floating at power-up.
// R09: If data was low at power-up, controller drives both lines high.
// R10: If lines floated at power-up, controller issues a software reset.
// R11: With both violations, drive lines high first, then software reset.
// R12: Start, nine clocks with data high, start returns decoder to idle.
// R13: Software reset has no effect during an internal write cycle.
// R14: A level is taken only after a stable interval after a synchroniser.
// R15: Guarded write ending in stop skips the write cycle, back to standby.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module eeprom_write_guard_bus_entry
  import eeprom_guard_pkg::*;
#(
  parameter logic [3:0] DEVICE_CODE = eeprom_guard_pkg::DEVICE_CODE_DEFAULT,
  parameter int WRITE_CYCLES = eeprom_guard_pkg::WRITE_CYCLE_CYCLES
)
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link clock and two-wire bus pins
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Protection inputs
  input wire logic write_guard_input,
  input wire logic supply_low,
  input wire logic power_on_reset
);
  import eeprom_guard_pkg::*;

  // Core domain registers
  logic [1:0] addr_select;
  logic [15:0] refused_count;
  logic [2:0] guard_c_sync;
  logic [2:0] supply_c_sync;
  logic [2:0] por_c_sync;
  logic [2:0] refuse_c_sync;
  logic refuse_c_seen;
  logic timer_busy;
  logic done_toggle;

  // Link domain registers
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic [2:0] guard_l_sync;
  logic [2:0] supply_l_sync;
  logic [2:0] por_l_sync;
  logic [2:0] sel0_sync;
  logic [2:0] sel1_sync;
  logic [2:0] done_sync;
  logic guard_l;
  logic supply_l;
  logic por_l;
  logic [1:0] sel_l;
  logic done_seen;
  logic req_toggle;
  logic refuse_toggle;
  link_state_type state;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic guard_seen;
  logic [MEM_ADDR_BITS-1:0] ptr;
  logic [PAGE_BYTES-1:0] page_valid;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [7:0] mem [2**MEM_ADDR_BITS];

  // Glitch filtering on both pins, synchroniser first [R01] [R14]
  pin_filter #(.STABLE(FILTER_CYCLES)) u_scl_filter
  (
    .clk(link_clk),
    .rst(rst),
    .pin(scl_in),
    .level(scl_f)
  );

  pin_filter #(.STABLE(FILTER_CYCLES)) u_sda_filter
  (
    .clk(link_clk),
    .rst(rst),
    .pin(sda_in),
    .level(sda_f)
  );

  write_timer #(.CYCLES(WRITE_CYCLES)) u_write_timer
  (
    .core_clk(core_clk),
    .rst(rst),
    .req_toggle(req_toggle),
    .done_toggle(done_toggle),
    .busy(timer_busy)
  );

  // Link side decode of bus events
  wire scl_rise = scl_f && !scl_q;
  wire scl_fall = !scl_f && scl_q;
  wire start_det = scl_f && scl_q && sda_q && !sda_f;
  wire stop_det = scl_f && scl_q && !sda_q && sda_f;
  wire done_evt =
    (done_sync[1] == done_sync[2]) && (done_sync[2] != done_seen);
  wire write_busy = (req_toggle != done_seen);
  // Bus is ignored while writing or in power-on reset [R05] [R13]
  wire hold_idle = write_busy || por_l;
  wire active = (state != st_idle) && (state != st_ignore);
  wire addr_match =
    (shifter[7:4] == DEVICE_CODE) &&
    (shifter[3:1] == {ADDR_SELECT_BIT2, sel_l[1], sel_l[0]});
  wire byte_end = scl_fall && (bit_cnt == BITS_BYTE);
  wire ack_end = scl_fall && (bit_cnt == BITS_ACK_SLOT);
  wire ack_byte = (state == st_addr) ? (addr_match && !shifter[0])
                : active;
  wire write_ready = (state == st_data) && (page_valid != '0);
  // Guard sampled anywhere between start and stop blocks the write [R02]
  wire guarded = guard_seen || guard_l;
  wire [4:0] page_ofs = ptr[4:0];

  // Level crossings into the link domain, third stage is the one used
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      guard_l_sync <= 3'h0;
      supply_l_sync <= 3'h0;
      por_l_sync <= 3'h7;
      sel0_sync <= 3'h0;
      sel1_sync <= 3'h0;
      done_sync <= 3'h0;
    end
    else
    begin
      guard_l_sync <= {guard_l_sync[1:0], write_guard_input};
      supply_l_sync <= {supply_l_sync[1:0], supply_low};
      por_l_sync <= {por_l_sync[1:0], power_on_reset};
      sel0_sync <= {sel0_sync[1:0], addr_select[0]};
      sel1_sync <= {sel1_sync[1:0], addr_select[1]};
      done_sync <= {done_sync[1:0], done_toggle};
    end
  end

  // Change accepted once second and third stage agree
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      guard_l <= 1'h0;
      supply_l <= 1'h0;
      por_l <= 1'h1;
      sel_l <= ADDR_SELECT_RESET;
    end
    else
    begin
      if (guard_l_sync[1] == guard_l_sync[2])
        guard_l <= guard_l_sync[2];
      if (supply_l_sync[1] == supply_l_sync[2])
        supply_l <= supply_l_sync[2];
      if (por_l_sync[1] == por_l_sync[2])
        por_l <= por_l_sync[2];
      if (sel0_sync[1] == sel0_sync[2])
        sel_l[0] <= sel0_sync[2];
      if (sel1_sync[1] == sel1_sync[2])
        sel_l[1] <= sel1_sync[2];
    end
  end

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end
    else
    begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Open-drain data pin: only ever pulls low
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      sda_out <= 1'h0;
    else
      sda_out <= 1'h0;
  end

  // Command decoder; outside power-on reset and write cycles any start restarts address reception, so the
  // dummy-clock reset decodes an all-ones address into st_ignore and the closing start restarts it [R12]
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shifter <= 8'h0;
      sda_oe <= 1'h0;
      guard_seen <= 1'h0;
      req_toggle <= 1'h0;
      refuse_toggle <= 1'h0;
      ptr <= '0;
      page_valid <= '0;
    end
    else if (hold_idle)
    begin
      state <= st_idle; // [R05] [R13]
      bit_cnt <= 4'h0;
      sda_oe <= 1'h0;
    end
    else if (start_det)
    begin
      state <= st_addr; // [R12]
      bit_cnt <= 4'h0;
      sda_oe <= 1'h0;
      guard_seen <= guard_l;
    end
    else if (stop_det)
    begin
      state <= st_idle;
      sda_oe <= 1'h0;
      if (write_ready && guarded)
        refuse_toggle <= ~refuse_toggle; // [R02] [R15]
      else if (write_ready && !supply_l)
        req_toggle <= ~req_toggle; // [R04]
    end
    else
    begin
      if (active)
        guard_seen <= guarded; // [R02]
      if (scl_rise && active && (bit_cnt < BITS_BYTE))
      begin
        shifter <= {shifter[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (byte_end)
      begin
        bit_cnt <= BITS_ACK_SLOT;
        sda_oe <= ack_byte;
        case (state)
          st_addr:
            state <= ack_byte ? st_addr_hi : st_ignore;
          st_addr_hi:
          begin
            ptr[MEM_ADDR_BITS-1:8] <= shifter[MEM_ADDR_BITS-9:0];
            state <= st_addr_lo;
          end
          st_addr_lo:
          begin
            ptr[7:0] <= shifter;
            page_valid <= '0;
            state <= st_data;
          end
          st_data:
          begin
            page_buf[page_ofs] <= shifter;
            page_valid[page_ofs] <= 1'h1;
            // Pointer wraps inside the page
            ptr[4:0] <= page_ofs + 5'h1;
          end
          default:
            state <= st_ignore;
        endcase
      end
      if (ack_end)
      begin
        bit_cnt <= 4'h0;
        sda_oe <= 1'h0;
      end
    end
  end

  // Page commit at the end of the timed write cycle; page is stable
  // because the bus is ignored while the cycle runs
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      done_seen <= 1'h0;
    else if (done_evt)
      done_seen <= done_sync[2];
  end

  always_ff @(posedge link_clk)
  begin
    if (done_evt)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_valid[i])
          mem[{ptr[MEM_ADDR_BITS-1:5], 5'(i)}] <= page_buf[i];
      end
    end
  end

  // Core side crossings
  wire refuse_evt =
    (refuse_c_sync[1] == refuse_c_sync[2]) &&
    (refuse_c_sync[2] != refuse_c_seen);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      guard_c_sync <= 3'h0;
      supply_c_sync <= 3'h0;
      por_c_sync <= 3'h7;
      refuse_c_sync <= 3'h0;
    end
    else
    begin
      guard_c_sync <= {guard_c_sync[1:0], write_guard_input};
      supply_c_sync <= {supply_c_sync[1:0], supply_low};
      por_c_sync <= {por_c_sync[1:0], power_on_reset};
      refuse_c_sync <= {refuse_c_sync[1:0], refuse_toggle};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      refuse_c_seen <= 1'h0;
      refused_count <= 16'h0;
    end
    else if (refuse_evt)
    begin
      refuse_c_seen <= refuse_c_sync[2];
      refused_count <= refused_count + 16'h1;
    end
  end

  // Avalon-MM slave: one wait cycle then answer
  wire take = (avs_read || avs_write) && avs_waitrequest;
  // Writes land only at the edge where the master sees waitrequest low
  wire accept = (avs_read || avs_write) && !avs_waitrequest;
  wire hit_ctrl = (avs_address == CTRL_OFS);
  wire hit_status = (avs_address == STATUS_OFS);
  wire hit_refused = (avs_address == REFUSED_OFS);
  wire [31:0] status_word = {28'h0, por_c_sync[2], supply_c_sync[2],
                             guard_c_sync[2], timer_busy};
  wire [31:0] read_mux = hit_ctrl ? {30'h0, addr_select}
                       : hit_status ? status_word
                       : hit_refused ? {16'h0, refused_count}
                       : 32'h0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'h1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= !take;
      avs_readdata <= (take && avs_read) ? read_mux : 32'h0;
    end
  end

  // Select bits default to zero and live only here [R06]
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      addr_select <= ADDR_SELECT_RESET; // [R06]
    else if (accept && avs_write && hit_ctrl)
      addr_select <= avs_writedata[1:0];
  end
endmodule

// ==== src/eeprom_guard_pkg.sv ====
// Shared constants and types for the EEPROM write-guard front end
package eeprom_guard_pkg;
  localparam int GLITCH_NS = 100;
  localparam int LINK_PERIOD_NS = 80;
  localparam int CORE_PERIOD_NS = 100;
  // Stable for strictly longer than the glitch width
  localparam int FILTER_CYCLES = GLITCH_NS / LINK_PERIOD_NS + 1;
  localparam int WRITE_CYCLE_US = 5000;
  localparam int WRITE_CYCLE_CYCLES =
    WRITE_CYCLE_US * 1000 / CORE_PERIOD_NS;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_ADDR_BITS = 12;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] REFUSED_OFS = 4'h8;
  localparam logic [1:0] ADDR_SELECT_RESET = 2'h0;
  localparam logic ADDR_SELECT_BIT2 = 1'h1;
  // Arbitrary device code, chosen to name no real part
  localparam logic [3:0] DEVICE_CODE_DEFAULT = 4'h9;
  localparam logic [7:0] BIT_ACK = 8'h8;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK_SLOT = 4'h9;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_hi, st_addr_lo, st_data, st_ignore
  } link_state_type;
endpackage

// ==== src/pin_filter.sv ====
// Three-stage synchroniser and stability filter for one bus pin
`timescale 1ns/1ps
module pin_filter
#(
  parameter int STABLE = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pin and filtered level
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(STABLE + 1);
  logic [2:0] sync;
  logic [CW-1:0] cnt;
  wire agree = (sync[1] == sync[2]);
  wire differs = agree && (sync[2] != level);
  wire done = (cnt == CW'(STABLE - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync <= 3'h7;
    else
      sync <= {sync[1:0], pin};
  end

  // Short pulses restart the count and never reach the output
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      level <= 1'h1;
    end
    else if (!differs)
      cnt <= '0;
    else if (done)
    begin
      cnt <= '0;
      level <= sync[2];
    end
    else
      cnt <= cnt + CW'(1);
  end
endmodule

// ==== src/write_timer.sv ====
// Core-clock write cycle timer driven by a toggle request
`timescale 1ns/1ps
module write_timer
#(
  parameter int CYCLES = 50000
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request from the link domain and completion back
  input wire logic req_toggle,
  output logic done_toggle,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [2:0] req_sync;
  logic req_seen;
  logic [CW-1:0] cnt;
  wire req_evt = (req_sync[1] == req_sync[2]) && (req_sync[2] != req_seen);
  wire last = (cnt == CW'(CYCLES - 1));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      req_sync <= 3'h0;
    else
      req_sync <= {req_sync[1:0], req_toggle};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_seen <= 1'h0;
      busy <= 1'h0;
      cnt <= '0;
      done_toggle <= 1'h0;
    end
    else if (req_evt && !busy)
    begin
      req_seen <= req_sync[2];
      busy <= 1'h1;
      cnt <= '0;
    end
    else if (busy && last)
    begin
      busy <= 1'h0;
      done_toggle <= ~done_toggle;
    end
    else if (busy)
      cnt <= cnt + CW'(1);
  end
endmodule

// ==== sim/eeprom_write_guard_bus_entry_sva.sv ====
// Assertion checker for the EEPROM write-guard front end ports
`timescale 1ns/1ps
module eeprom_write_guard_bus_entry_sva
  import eeprom_guard_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and protection inputs
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic write_guard_input,
  input wire logic supply_low,
  input wire logic power_on_reset
);
  wire rd_ans = avs_read && !avs_waitrequest;
  wire st_ans = rd_ans && avs_address == STATUS_OFS;
  property p_answer;
    @(posedge core_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_single;
    @(posedge core_clk) disable iff (rst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_single: assert property (p_single) else $error("answer too long");
  property p_idle_zero;
    @(posedge core_clk) disable iff (rst) avs_waitrequest |-> !(|avs_readdata);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle data not 0");
  property p_ctrl_fmt;
    @(posedge core_clk) disable iff (rst)
      rd_ans && avs_address == CTRL_OFS |-> !(|avs_readdata);
  endproperty
  a_ctrl_fmt: assert property (p_ctrl_fmt) else $error("select bits");
  // Flags go through a synchroniser, so the level must settle first
  property p_guard_flag;
    @(posedge core_clk) disable iff (rst)
      write_guard_input [*6] ##0 st_ans |-> avs_readdata[1];
  endproperty
  a_guard_flag: assert property (p_guard_flag) else $error("guard");
  property p_supply_flag;
    @(posedge core_clk) disable iff (rst)
      supply_low [*6] ##0 st_ans |-> avs_readdata[2];
  endproperty
  a_supply_flag: assert property (p_supply_flag) else $error("low");
  property p_por_flag;
    @(posedge core_clk) disable iff (rst)
      power_on_reset [*6] ##0 st_ans |-> avs_readdata[3];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on");
  property p_por_quiet;
    @(posedge link_clk) disable iff (rst) power_on_reset [*8] |-> !sda_oe;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("ack in POR");
  property p_oe_stable;
    @(posedge link_clk) disable iff (rst)
      scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_oe_stable: assert property (p_oe_stable) else $error("sda moved");
  // Open drain: the data line is only ever pulled low, never driven high
  property p_drive_low;
    @(posedge link_clk) disable iff (rst) sda_oe |-> !sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda high");
  c_status: cover property (@(posedge core_clk) st_ans);
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
  c_guard: cover property (@(posedge core_clk) write_guard_input && st_ans);
endmodule
bind eeprom_write_guard_bus_entry eeprom_write_guard_bus_entry_sva
  eeprom_write_guard_bus_entry_sva_inst (.core_clk, .link_clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .scl_in, .sda_oe, .sda_out, .write_guard_input, .supply_low,
  .power_on_reset);

// ==== sim/i2c_ctrl_model.sv ====
// Behavioural two-wire bus controller driving clock and data
`timescale 1ns/1ps
module i2c_ctrl_model (
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  localparam int HALF = 1200;
  // Both lines driven high from time zero, never left floating
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start_cond;
    begin
      sda_drv = 1'b1;
      #HALF scl = 1'b1;
      #HALF sda_drv = 1'b0;
      #HALF scl = 1'b0;
    end
  endtask
  task automatic stop_cond;
    begin
      sda_drv = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda_drv = 1'b1;
      #HALF;
    end
  endtask
  // Optional glitch at the filter limit lands mid high phase
  task automatic clock_bit(input logic b, input logic g, output logic s);
    begin
      sda_drv = b;
      #HALF scl = 1'b1;
      #(HALF / 2) s = sda;
      if (g)
      begin
        scl = 1'b0;
        #100 scl = 1'b1;
      end
      #(HALF / 2) scl = 1'b0;
    end
  endtask
  task automatic send_byte(input logic [7:0] b, input logic g,
    output logic ack);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clock_bit(b[i], g, s);
      clock_bit(1'b1, 1'b0, s);
      ack = !s;
    end
  endtask
  task automatic sreset;
    logic s;
    begin
      start_cond();
      repeat (9) clock_bit(1'b1, 1'b0, s);
      start_cond();
    end
  endtask
endmodule

// ==== sim/test_eeprom_write_guard_bus_entry.sv ====
// Self-checking bench for the EEPROM write-guard front end
`timescale 1ns/1ps
module test_eeprom_write_guard_bus_entry
  import eeprom_guard_pkg::*;
;
  localparam int WC = 2000;
  localparam logic [7:0] DEV_W =
    {DEVICE_CODE_DEFAULT, ADDR_SELECT_BIT2, ADDR_SELECT_RESET, 1'b0};
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sda_out, sda_oe, scl, sda_drv, a;
  logic write_guard_input = 1'b0;
  logic supply_low = 1'b0;
  logic power_on_reset = 1'b1;
  wire sda_in = sda_drv & ~(sda_oe & ~sda_out);
  int errors = 0;
  int tests_run = 0;
  int na;
  logic [31:0] d;
  eeprom_write_guard_bus_entry #(.WRITE_CYCLES(WC))
    eeprom_write_guard_bus_entry_inst (.core_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .link_clk, .scl_in(scl), .sda_in, .sda_out, .sda_oe,
    .write_guard_input, .supply_low, .power_on_reset);
  i2c_ctrl_model i2c_ctrl_model_inst (.scl, .sda_drv, .sda(sda_in));
  initial
    forever #50 core_clk = ~core_clk;
  initial
  begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus_cycle(input logic wr, input logic [3:0] ad,
    input logic [31:0] wd, output logic [31:0] rd);
    begin
      @(posedge core_clk);
      avs_address <= ad;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge core_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [3:0] ad, input logic [31:0] m,
    input logic [31:0] e);
    begin
      bus_cycle(1'b0, ad, 32'h0, d);
      check(d & m, e);
    end
  endtask
  task automatic wr_cmd(input logic g, output int acks);
    logic [7:0] b [4];
    logic k;
    begin
      b = '{DEV_W, 8'h00, 8'h05, 8'hA5};
      acks = 0;
      i2c_ctrl_model_inst.start_cond();
      foreach (b[i])
      begin
        i2c_ctrl_model_inst.send_byte(b[i], g, k);
        acks += (k === 1'b1);
      end
      i2c_ctrl_model_inst.stop_cond();
    end
  endtask
  task automatic summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    #3000000;
    errors++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd_chk(STATUS_OFS, 32'h8, 32'h8);
    wr_cmd(1'b0, na);
    check(32'(na), 32'h0);
    @(posedge core_clk);
    power_on_reset <= 1'b0;
    repeat (20) @(posedge core_clk);
    i2c_ctrl_model_inst.sreset();
    rd_chk(CTRL_OFS, 32'hFFFFFFFF, 32'h0);
    rd_chk(REFUSED_OFS, 32'hFFFF, 32'h0);
    bus_cycle(1'b1, 4'hC, 32'h5A5A5A5A, d);
    rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
    $display("test power-up and reset values done");
    i2c_ctrl_model_inst.start_cond();
    i2c_ctrl_model_inst.send_byte(DEV_W, 1'b0, a);
    check({31'h0, a}, 32'h1);
    i2c_ctrl_model_inst.sreset();
    wr_cmd(1'b1, na);
    check(32'(na), 32'h4);
    rd_chk(STATUS_OFS, 32'h1, 32'h1);
    i2c_ctrl_model_inst.sreset();
    i2c_ctrl_model_inst.send_byte(DEV_W, 1'b0, a);
    check({31'h0, a}, 32'h0);
    repeat (WC) @(posedge core_clk);
    rd_chk(STATUS_OFS, 32'h1, 32'h0);
    $display("test glitches and software reset done");
    @(posedge core_clk);
    write_guard_input <= 1'b1;
    wr_cmd(1'b0, na);
    check(32'(na), 32'h4);
    rd_chk(STATUS_OFS, 32'h3, 32'h2);
    write_guard_input <= 1'b0;
    rd_chk(REFUSED_OFS, 32'hFFFF, 32'h1);
    $display("test write guard done");
    supply_low <= 1'b1;
    wr_cmd(1'b0, na);
    check(32'(na), 32'h4);
    rd_chk(STATUS_OFS, 32'h5, 32'h4);
    supply_low <= 1'b0;
    $display("test low supply done");
    summarize();
  end
endmodule
